// File: hdl/acc_datapath.sv
// accumulator, stack and load/store datapath of the controller cpu
`timescale 1ns/1ps
module acc_datapath
   import acc_stack_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // instruction port
   input  wire logic        instr_valid,
   input  wire instr_type   instr,
   output logic             instr_ready,
   // data memory
   output logic             mem_req,
   output logic             mem_we,
   output logic [15:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack,
   // constant table in program memory
   output logic             const_req,
   output logic [15:0]      constant_table_label,
   output logic [15:0]      const_index,
   input  wire logic [15:0] const_data,
   input  wire logic        const_ack,
   // discrete bit memory
   output logic             bit_we,
   output logic [15:0]      bit_addr,
   output logic             bit_value,
   // state
   output logic [31:0]      acc,
   output logic [31:0]      stack_level_one,
   output flags_type        flags
);

   // ----------------------------------------------------------------
   // state encoding
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_READ_LO  = 3'h1,
      ST_READ_HI  = 3'h2,
      ST_CONST    = 3'h3,
      ST_WRITE_LO = 3'h4,
      ST_WRITE_HI = 3'h5
   } state_type;

   function automatic logic is_load_op(input op_type op);
      return (op == OP_LOAD_WORD) || (op == OP_LOAD_INDEXED_CONSTANT) ||
             (op == OP_LOAD_REAL_MEM) || (op == OP_LOAD_REAL_IMM);
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   state_type   state_reg;
   state_type   state_next;
   logic [31:0] acc_reg;
   logic [31:0] acc_next;
   flags_type   flags_reg;
   flags_type   flags_next;
   op_type      op_reg;
   op_type      op_next;
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic [15:0] index_reg;
   logic [15:0] index_next;
   logic [15:0] wdata_reg;
   logic [15:0] wdata_next;
   logic [15:0] low_word_reg;
   logic [15:0] low_word_next;
   logic        last_load_reg;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic        bits_busy;
   logic        accept;
   logic        push_now;
   logic        pop_now;
   logic        bits_start;
   logic [31:0] level_one_eff;
   logic [31:0] stack_top;
   logic [31:0] and_double_result;
   logic [31:0] and_word_result;

   assign instr_ready       = (state_reg == ST_IDLE) && !bits_busy;
   assign accept            = instr_valid && instr_ready;
   assign push_now          = accept && is_load_op(instr.op) && last_load_reg;
   assign pop_now           = accept && (instr.op == OP_POP);
   assign bits_start        = accept && (instr.op == OP_STORE_BIT_FIELD);
   assign level_one_eff     = push_now ? acc_reg : stack_top;
   assign and_double_result = acc_reg & instr.imm;
   assign and_word_result   = {WORD_ZERO, acc_reg[15:0] & mem_rdata};

   assign mem_req              = (state_reg == ST_READ_LO) || (state_reg == ST_READ_HI) ||
                                 (state_reg == ST_WRITE_LO) || (state_reg == ST_WRITE_HI);
   assign mem_we               = (state_reg == ST_WRITE_LO) || (state_reg == ST_WRITE_HI);
   assign mem_addr             = addr_reg;
   assign mem_wdata            = wdata_reg;
   assign const_req            = (state_reg == ST_CONST);
   assign constant_table_label = addr_reg;
   assign const_index          = index_reg;
   assign acc                  = acc_reg;
   assign stack_level_one      = stack_top;
   assign flags                = flags_reg;

   // ----------------------------------------------------------------
   // next state and datapath
   // ----------------------------------------------------------------
   always_comb begin
      state_next    = state_reg;
      acc_next      = acc_reg;
      flags_next    = flags_reg;
      op_next       = op_reg;
      addr_next     = addr_reg;
      index_next    = index_reg;
      wdata_next    = wdata_reg;
      low_word_next = low_word_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               op_next    = instr.op;
               addr_next  = instr.addr;
               index_next = level_one_eff[15:0];
               case (instr.op)
                  OP_LOAD_WORD, OP_LOAD_REAL_MEM, OP_AND_WORD: begin
                     state_next = ST_READ_LO;
                  end
                  OP_LOAD_INDEXED_CONSTANT: begin
                     state_next = ST_CONST;
                  end
                  OP_LOAD_REAL_IMM: begin
                     acc_next                  = instr.imm;
                     flags_next.load_zero_flag = (instr.imm == ACC_RESET);
                  end
                  OP_STORE_WORD, OP_STORE_DOUBLE_WORD: begin
                     wdata_next = acc_reg[15:0];
                     state_next = ST_WRITE_LO;
                  end
                  OP_STORE_INDEXED_WORD: begin
                     addr_next  = instr.addr + acc_reg[15:0];
                     wdata_next = stack_top[15:0];
                     state_next = ST_WRITE_LO;
                  end
                  OP_POP: begin
                     acc_next = stack_top;
                  end
                  OP_AND_DOUBLE_IMMEDIATE: begin
                     acc_next                        = and_double_result;
                     flags_next.zero_result_flag     = (and_double_result == ACC_RESET);
                     flags_next.negative_result_flag = and_double_result[31];
                  end
                  default: begin
                     state_next = ST_IDLE;
                  end
               endcase
            end
         end
         ST_READ_LO: begin
            if (mem_ack) begin
               case (op_reg)
                  OP_LOAD_WORD: begin
                     acc_next                  = {WORD_ZERO, mem_rdata};
                     flags_next.load_zero_flag = (mem_rdata == WORD_ZERO);
                     state_next                = ST_IDLE;
                  end
                  OP_AND_WORD: begin
                     acc_next                    = and_word_result;
                     flags_next.zero_result_flag = (and_word_result == ACC_RESET);
                     state_next                  = ST_IDLE;
                  end
                  default: begin
                     low_word_next = mem_rdata;
                     addr_next     = addr_reg + 16'h0001;
                     state_next    = ST_READ_HI;
                  end
               endcase
            end
         end
         ST_READ_HI: begin
            if (mem_ack) begin
               acc_next                  = {mem_rdata, low_word_reg};
               flags_next.load_zero_flag = ({mem_rdata, low_word_reg} == ACC_RESET);
               state_next                = ST_IDLE;
            end
         end
         ST_CONST: begin
            if (const_ack) begin
               acc_next                  = {WORD_ZERO, const_data};
               flags_next.load_zero_flag = (const_data == WORD_ZERO);
               state_next                = ST_IDLE;
            end
         end
         ST_WRITE_LO: begin
            if (mem_ack) begin
               case (op_reg)
                  OP_STORE_DOUBLE_WORD: begin
                     addr_next  = addr_reg + 16'h0001;
                     wdata_next = acc_reg[31:16];
                     state_next = ST_WRITE_HI;
                  end
                  OP_STORE_INDEXED_WORD: begin
                     acc_next   = {WORD_ZERO, acc_reg[15:0]};
                     state_next = ST_IDLE;
                  end
                  default: begin
                     state_next = ST_IDLE;
                  end
               endcase
            end
         end
         ST_WRITE_HI: begin
            if (mem_ack) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // sequential state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= ST_IDLE;
         acc_reg       <= ACC_RESET;
         flags_reg     <= '{FLAG_RESET, FLAG_RESET, FLAG_RESET};
         op_reg        <= OP_NONE;
         addr_reg      <= WORD_ZERO;
         index_reg     <= WORD_ZERO;
         wdata_reg     <= WORD_ZERO;
         low_word_reg  <= WORD_ZERO;
         last_load_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         acc_reg      <= acc_next;
         flags_reg    <= flags_next;
         op_reg       <= op_next;
         addr_reg     <= addr_next;
         index_reg    <= index_next;
         wdata_reg    <= wdata_next;
         low_word_reg <= low_word_next;
         if (accept) begin
            last_load_reg <= is_load_op(instr.op);
         end
      end
   end

   // ----------------------------------------------------------------
   // stack and bit field store
   // ----------------------------------------------------------------
   acc_stack #(
      .DEPTH (DEPTH)
   ) u_stack (
      .clk       (clk),
      .rstn      (rstn),
      .push      (push_now),
      .pop       (pop_now),
      .push_data (acc_reg),
      .top       (stack_top)
   );

   bit_field_writer u_bits (
      .clk        (clk),
      .rstn       (rstn),
      .start      (bits_start),
      .start_addr (instr.addr),
      .count      (instr.count),
      .data       (acc_reg),
      .bit_we     (bit_we),
      .bit_addr   (bit_addr),
      .bit_value  (bit_value),
      .busy       (bits_busy)
   );

endmodule

// File: hdl/acc_stack.sv
// eight-level 32-bit accumulator stack with push and pop
`timescale 1ns/1ps
module acc_stack
   import acc_stack_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // control
   input  wire logic        push,
   input  wire logic        pop,
   input  wire logic [31:0] push_data,
   // level one
   output logic [31:0]      top
);

   logic [31:0] level_reg [DEPTH];

   assign top = level_reg[0];

   // ----------------------------------------------------------------
   // push drops the bottom entry, pop refills the bottom with zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            level_reg[i] <= ACC_RESET;
         end
      end else if (push) begin
         level_reg[0] <= push_data;
         for (int i = 1; i < DEPTH; i++) begin
            level_reg[i] <= level_reg[i-1];
         end
      end else if (pop) begin
         level_reg[DEPTH-1] <= ACC_RESET;
         for (int i = 0; i < DEPTH - 1; i++) begin
            level_reg[i] <= level_reg[i+1];
         end
      end
   end

endmodule

// File: hdl/acc_stack_pkg.sv
// shared types and constants for the accumulator and stack datapath
package acc_stack_pkg;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int          ADDR_W      = 16;
   localparam int          WORD_W      = 16;
   localparam int          ACC_W       = 32;
   localparam int          STACK_DEPTH = 8;
   localparam int          COUNT_W     = 6;
   localparam logic [31:0] ACC_RESET   = 32'h0000_0000;
   localparam logic [15:0] WORD_ZERO   = 16'h0000;
   localparam logic        FLAG_RESET  = 1'b0;
   localparam logic [5:0]  COUNT_MIN   = 6'h01;
   localparam logic [5:0]  COUNT_MAX   = 6'h20;

   // ----------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE                  = 4'h0,
      OP_LOAD_WORD             = 4'h1,
      OP_LOAD_INDEXED_CONSTANT = 4'h2,
      OP_LOAD_REAL_MEM         = 4'h3,
      OP_LOAD_REAL_IMM         = 4'h4,
      OP_STORE_WORD            = 4'h5,
      OP_STORE_DOUBLE_WORD     = 4'h6,
      OP_STORE_BIT_FIELD       = 4'h7,
      OP_STORE_INDEXED_WORD    = 4'h8,
      OP_POP                   = 4'h9,
      OP_AND_WORD              = 4'ha,
      OP_AND_DOUBLE_IMMEDIATE  = 4'hb
   } op_type;

   typedef struct packed {
      op_type      op;
      logic [15:0] addr;
      logic [31:0] imm;
      logic [5:0]  count;
   } instr_type;

   typedef struct packed {
      logic zero_result_flag;
      logic negative_result_flag;
      logic load_zero_flag;
   } flags_type;

endpackage

// File: hdl/bit_field_writer.sv
// serialises the low bits of a word into consecutive bit locations
`timescale 1ns/1ps
module bit_field_writer
   import acc_stack_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // start request
   input  wire logic        start,
   input  wire logic [15:0] start_addr,
   input  wire logic [5:0]  count,
   input  wire logic [31:0] data,
   // bit memory
   output logic             bit_we,
   output logic [15:0]      bit_addr,
   output logic             bit_value,
   // status
   output logic             busy
);

   logic [5:0]  left_reg;
   logic [31:0] data_reg;
   logic        we_reg;
   logic [15:0] addr_reg;
   logic        value_reg;

   assign busy      = (left_reg != 6'h00);
   assign bit_we    = we_reg;
   assign bit_addr  = addr_reg;
   assign bit_value = value_reg;

   // ----------------------------------------------------------------
   // one bit per cycle, least significant bit first
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         left_reg  <= 6'h00;
         data_reg  <= ACC_RESET;
         we_reg    <= 1'b0;
         addr_reg  <= WORD_ZERO;
         value_reg <= 1'b0;
      end else if (start) begin
         left_reg <= count;
         data_reg <= data;
         addr_reg <= start_addr - 16'h0001;
         we_reg   <= 1'b0;
      end else if (busy) begin
         we_reg    <= 1'b1;
         value_reg <= data_reg[0];
         data_reg  <= {1'b0, data_reg[31:1]};
         addr_reg  <= addr_reg + 16'h0001;
         left_reg  <= left_reg - 6'h01;
      end else begin
         we_reg <= 1'b0;
      end
   end

endmodule

// File: tb/acc_datapath_properties.sv
// concurrent checks on the accumulator datapath ports
`timescale 1ns/1ps
module acc_datapath_properties
   import acc_stack_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // instruction port
   input wire logic        instr_valid,
   input wire instr_type   instr,
   input wire logic        instr_ready,
   // data memory
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic        mem_ack,
   // state
   input wire logic [31:0] acc,
   input wire logic [31:0] stack_level_one,
   input wire flags_type   flags
);
   wire logic take = instr_valid && instr_ready;
   wire logic is_ld = take && instr.op inside {OP_LOAD_WORD, OP_LOAD_INDEXED_CONSTANT, OP_LOAD_REAL_MEM,
                                               OP_LOAD_REAL_IMM};
   op_type      op_reg;
   logic        ld_reg;
   logic [15:0] base_reg;
   logic [1:0]  ack_reg;
   // ----------------------------------------------------------------
   // operation in flight and its completed accesses
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_reg <= OP_NONE;
         ld_reg <= 1'b0;
         base_reg <= 16'h0000;
         ack_reg <= 2'h0;
      end else if (take) begin
         op_reg <= instr.op;
         ld_reg <= is_ld;
         base_reg <= instr.addr;
         ack_reg <= 2'h0;
      end else if (mem_ack) begin
         ack_reg <= ack_reg + 2'h1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_load_pushes_acc: assert property (is_ld && ld_reg |=> stack_level_one == $past(acc))
      else $error("second load did not push");
   a_real_imm_load: assert property (take && instr.op == OP_LOAD_REAL_IMM |=> acc == $past(instr.imm)
      && flags.load_zero_flag == ($past(instr.imm) == 32'h0000_0000)) else $error("immediate load");
   a_word_load_low: assert property (mem_ack && op_reg == OP_LOAD_WORD
      |=> acc == {16'h0000, $past(mem_rdata)}) else $error("word load value");
   a_stores_keep_state: assert property (take && instr.op inside {OP_STORE_WORD, OP_STORE_DOUBLE_WORD,
      OP_STORE_BIT_FIELD} |=> ($stable(acc) && $stable(stack_level_one) && $stable(flags)) [*2])
      else $error("store changed state");
   a_store_word_order: assert property (mem_req && op_reg inside {OP_STORE_WORD, OP_STORE_DOUBLE_WORD}
      |-> mem_we && mem_addr == base_reg + 16'(ack_reg)
      && mem_wdata == (ack_reg == 2'h0 ? acc[15:0] : acc[31:16])) else $error("store word or address");
   a_indexed_target: assert property (mem_req && op_reg == OP_STORE_INDEXED_WORD |-> mem_we
      && mem_addr == base_reg + acc[15:0] && mem_wdata == stack_level_one[15:0]) else $error("indexed store");
   a_indexed_clears: assert property (mem_ack && op_reg == OP_STORE_INDEXED_WORD |=> acc[31:16] == 16'h0000)
      else $error("upper half kept");
   a_pop_moves_top: assert property (take && instr.op == OP_POP |=> acc == $past(stack_level_one))
      else $error("pop value");
   a_and_double_flags: assert property (take && instr.op == OP_AND_DOUBLE_IMMEDIATE |=> acc ==
      ($past(acc) & $past(instr.imm)) && flags.zero_result_flag == (acc == 32'h0)
      && flags.negative_result_flag == acc[31]) else $error("double and");
   a_and_word_result: assert property (mem_ack && op_reg == OP_AND_WORD |=> acc ==
      ($past(acc) & {16'h0000, $past(mem_rdata)}) && flags.zero_result_flag == (acc == 32'h0))
      else $error("word and");
   c_load_push: cover property (is_ld && ld_reg);
   c_double_store: cover property (mem_ack && op_reg == OP_STORE_DOUBLE_WORD && ack_reg == 2'h1);
   c_pop_empty: cover property (take && instr.op == OP_POP && stack_level_one == 32'h0);
endmodule

// File: tb/acc_datapath_tb.sv
// self-checking bench for the accumulator and stack datapath
`timescale 1ns/1ps
module acc_datapath_tb
   import acc_stack_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic instr_valid = 1'b0;
   instr_type instr = '0;
   logic [3:0] lat = 4'h0;
   logic instr_ready, mem_req, mem_we, mem_ack, const_req, const_ack, bit_we, bit_value;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, label, const_index, const_data, bit_addr;
   logic [31:0] acc, top;
   flags_type flags;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   acc_datapath u_acc_datapath (.clk, .rstn, .instr_valid, .instr, .instr_ready, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_rdata, .mem_ack, .const_req, .constant_table_label(label), .const_index, .const_data,
      .const_ack, .bit_we, .bit_addr, .bit_value, .acc, .stack_level_one(top), .flags);
   data_memory_model u_m (.clk, .rstn, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
      .const_req, .constant_table_label(label), .const_index, .const_data, .const_ack, .bit_we, .bit_addr,
      .bit_value);
   function automatic logic [15:0] pat(input logic [7:0] i);
      return {i, ~i};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flags(input flags_type got, input flags_type exp);
      chk({29'h0, got}, {29'h0, exp});
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // offers one instruction and waits until it completes
   task automatic run(input op_type op, input logic [15:0] a, input logic [31:0] imm, input logic [5:0] n);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= '{op, a, imm, n};
      do @(negedge clk); while (instr_ready !== 1'b1);
      @(posedge clk);
      instr_valid <= 1'b0;
      do @(negedge clk); while (instr_ready !== 1'b1);
   endtask
   task automatic t_loads;
      lat <= 4'h3;
      run(OP_LOAD_REAL_IMM, 16'h0, 32'hdead_beef, 6'h0);
      run(OP_LOAD_WORD, 16'h000a, 32'h0, 6'h0);
      chk(acc, {16'h0, pat(8'h0a)});
      chk(top, 32'hdead_beef);
      chk_flags(flags, 3'b000);
      run(OP_LOAD_REAL_IMM, 16'h0, 32'h3, 6'h0);
      run(OP_LOAD_INDEXED_CONSTANT, 16'h0020, 32'h0, 6'h0);
      chk(acc, {16'h0, ~8'h23, 8'h23});
      run(OP_LOAD_REAL_MEM, 16'h0005, 32'h0, 6'h0);
      chk(acc, {pat(8'h06), pat(8'h05)});
      run(OP_LOAD_REAL_IMM, 16'h0, 32'h0, 6'h0);
      chk_flags(flags, 3'b001);
   endtask
   task automatic t_stores;
      logic [31:0] v;
      v = 32'h8000_0005;
      lat <= 4'h0;
      run(OP_LOAD_REAL_IMM, 16'h0, 32'h1234_8765, 6'h0);
      run(OP_STORE_WORD, 16'h0040, 32'h0, 6'h0);
      run(OP_STORE_DOUBLE_WORD, 16'h0050, 32'h0, 6'h0);
      chk({16'h0, u_m.mem[8'h40]}, 32'h8765);
      chk({u_m.mem[8'h51], u_m.mem[8'h50]}, 32'h1234_8765);
      chk(acc, 32'h1234_8765);
      chk(top, 32'h0);
      run(OP_LOAD_REAL_IMM, 16'h0, v, 6'h0);
      run(OP_STORE_BIT_FIELD, 16'h0064, 32'h0, 6'h20);
      run(OP_STORE_BIT_FIELD, 16'h00c8, 32'h0, 6'h01);
      // the last bit pulse is still out when ready returns; let it land
      @(negedge clk);
      for (int i = 0; i < 32; i++) chk({31'h0, u_m.bits[8'h64 + i]}, {31'h0, v[i]});
      chk({30'h0, u_m.bits[8'hc9], u_m.bits[8'hc8]}, 32'h1);
      chk(acc, v);
   endtask
   task automatic t_index_pop;
      run(OP_LOAD_REAL_IMM, 16'h0, 32'h0000_3544, 6'h0);
      run(OP_LOAD_REAL_IMM, 16'h0, 32'hffff_0015, 6'h0);
      run(OP_STORE_INDEXED_WORD, 16'h0060, 32'h0, 6'h0);
      chk({16'h0, u_m.mem[8'h75]}, 32'h3544);
      chk(acc, 32'h0000_0015);
      for (int i = 1; i <= 9; i++) run(OP_LOAD_REAL_IMM, 16'h0, 32'(i), 6'h0);
      for (int i = 8; i >= 0; i--) begin
         run(OP_POP, 16'h0, 32'h0, 6'h0);
         chk(acc, 32'(i));
      end
   endtask
   task automatic t_and;
      lat <= 4'h2;
      run(OP_LOAD_REAL_IMM, 16'h0, 32'hf0f0_ff00, 6'h0);
      run(OP_AND_DOUBLE_IMMEDIATE, 16'h0, 32'h8f00_0f0f, 6'h0);
      chk(acc, 32'h8000_0f00);
      chk_flags(flags, 3'b010);
      run(OP_AND_DOUBLE_IMMEDIATE, 16'h0, 32'h0000_f0f0, 6'h0);
      chk_flags(flags, 3'b100);
      run(OP_LOAD_WORD, 16'h0007, 32'h0, 6'h0);
      chk_flags(flags, 3'b100);
      run(OP_AND_WORD, 16'h0007, 32'h0, 6'h0);
      chk(acc, {16'h0, pat(8'h07)});
      chk_flags(flags, 3'b000);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk({31'h0, instr_ready}, 32'h1);
      chk(acc, ACC_RESET);
      chk(top, 32'h0);
      t_loads();
      t_stores();
      t_index_pop();
      t_and();
      complete_run();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         complete_run();
      end
   end
endmodule
bind acc_datapath acc_datapath_properties u_props (.clk, .rstn, .instr_valid, .instr, .instr_ready, .mem_req,
   .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .acc, .stack_level_one, .flags);

// File: tb/data_memory_model.sv
// data, constant and bit memories on the datapath far side
`timescale 1ns/1ps
module data_memory_model
   import acc_stack_pkg::*;
(
   // clock, reset and answer delay in cycles
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  lat,
   // data memory
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic [15:0]      mem_rdata,
   output logic             mem_ack,
   // constant table
   input  wire logic        const_req,
   input  wire logic [15:0] constant_table_label,
   input  wire logic [15:0] const_index,
   output logic [15:0]      const_data,
   output logic             const_ack,
   // bit memory
   input  wire logic        bit_we,
   input  wire logic [15:0] bit_addr,
   input  wire logic        bit_value
);
   logic [15:0] mem [256];
   logic        bits [256];
   logic [15:0] rd_reg;
   logic [3:0]  cnt_reg;
   wire logic       any_req = (mem_req && !mem_ack) || (const_req && !const_ack);
   wire logic [7:0] ci = 8'(constant_table_label + const_index);
   // released data lines show the inverse of the last value
   assign mem_rdata = mem_ack ? rd_reg : ~rd_reg;
   assign const_data = const_ack ? rd_reg : ~rd_reg;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = {8'(i), ~8'(i)};
         bits[i] = 1'b0;
      end
   end
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_ack <= 1'b0;
         const_ack <= 1'b0;
         cnt_reg <= 4'h0;
      end else begin
         mem_ack <= 1'b0;
         const_ack <= 1'b0;
         if (bit_we) bits[bit_addr[7:0]] <= bit_value;
         if (any_req && cnt_reg < lat) begin
            cnt_reg <= cnt_reg + 4'h1;
         end else if (any_req) begin
            cnt_reg <= 4'h0;
            mem_ack <= mem_req;
            const_ack <= const_req && !mem_req;
            rd_reg <= mem_req ? mem[mem_addr[7:0]] : {~ci, ci};
            if (mem_req && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
         end
      end
   end
endmodule
